//--- rtl/datagram_seq_consts.vh
`ifndef DATAGRAM_SEQ_CONSTS_VH
`define DATAGRAM_SEQ_CONSTS_VH

// register_or_ram_select is this byte address bit
`define RRS_BIT          7
`define ADDR_W           8
// control registers (register_or_ram_select = 0)
`define OFF_CTRL         7'h00
`define OFF_STATUS       7'h04
`define CTRL_LAST_LSB    0
`define CTRL_LAST_MSB    1
`define CTRL_SEND_BIT    8
`define STAT_BUSY_BIT    0
`define STAT_ADDR_LSB    4
`define STAT_ADDR_MSB    5
`define LAST_RST         2'h2
// table layout: 32 words of two 6-bit entries
`define TAB_WORDS        32
`define TAB_ENTRIES      64
`define ENT_W            6
`define EVEN_LSB         0
`define ODD_LSB          6
`define NXM_BIT          5
// selection codes
`define CODE_COIL_LAST   5'h0f
`define CODE_ZERO        5'h10
`define CODE_ONE         5'h11
`define CODE_DIR         5'h12
`define CODE_STEP        5'h13
// default entries
`define DEF_DRIVER_LEN   12
`define DEF_ENTRIES      36
// axi responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
// sequencer states
`define ST_IDLE          3'h0
`define ST_SETUP         3'h1
`define ST_LOW           3'h2
`define ST_HIGH          3'h3
`define ST_HOLD          3'h4
// serial half-bit period in aclk cycles
`define HALF_BIT_CYCLES  8

`endif

//--- rtl/driver_chain_datagram_sequencer.v
// Overview of operation
// - codes 0..5 pick coil A current bits
// - code 6 phase A, code 7 decay A
// - codes 8..15 same layout for coil B
// - code 16 sends 0, 17 sends 1
// - code 18 sends motor direction bit
// - code 19 sends motor step bit
// - transmit only on request
// - snapshot all motor signals before shifting
// - start at motor 0, table entry 0
// - flag at last driver ends datagram
// - after end, address zero, wait idle
// - table access allowed during transmission
// - reset values need no transmission
// - table preloaded with twelve-bit driver layout
// - motion writes may request datagrams
// - entry is code plus next-motor flag
// - 32 words of two entries, sequential
// - select bit picks table or registers
`timescale 1ns/100ps
`include "datagram_seq_consts.vh"

module driver_chain_datagram_sequencer #(
    parameter MOTORS   = 3,
    parameter HALF_BIT = `HALF_BIT_CYCLES
) (
    // clock and reset
    input  wire                  aclk,
    input  wire                  aresetn,
    // axi4-lite slave
    input  wire [`ADDR_W-1:0]    s_axi_awaddr,
    input  wire                  s_axi_awvalid,
    output wire                  s_axi_awready,
    input  wire [31:0]           s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    input  wire                  s_axi_wvalid,
    output wire                  s_axi_wready,
    output reg  [1:0]            s_axi_bresp,
    output reg                   s_axi_bvalid,
    input  wire                  s_axi_bready,
    input  wire [`ADDR_W-1:0]    s_axi_araddr,
    input  wire                  s_axi_arvalid,
    output wire                  s_axi_arready,
    output reg  [31:0]           s_axi_rdata,
    output reg  [1:0]            s_axi_rresp,
    output reg                   s_axi_rvalid,
    input  wire                  s_axi_rready,
    // motor unit signals, one slice per motor except the shared send_request
    input  wire [6*MOTORS-1:0]   coil_a_current,
    input  wire [MOTORS-1:0]     coil_a_phase_polarity,
    input  wire [MOTORS-1:0]     coil_a_fast_decay,
    input  wire [6*MOTORS-1:0]   coil_b_current,
    input  wire [MOTORS-1:0]     coil_b_phase_polarity,
    input  wire [MOTORS-1:0]     coil_b_fast_decay,
    input  wire [MOTORS-1:0]     direction,
    input  wire [MOTORS-1:0]     step,
    input  wire                  send_request,
    // driver chain
    output reg                   drv_sclk,
    output reg                   drv_mosi,
    output reg                   drv_cs_n,
    output wire                  busy
);

    reg  [`ENT_W-1:0]  table_ram [0:`TAB_ENTRIES-1];
    reg  [16*MOTORS-1:0] snap_coil;
    reg  [MOTORS-1:0]  snap_dir;
    reg  [MOTORS-1:0]  snap_step;
    reg  [1:0]         last_driver_index;
    reg  [1:0]         motor_driver_address;
    reg  [5:0]         entry_ptr;
    reg  [2:0]         state;
    reg                pending;
    reg  [7:0]         div_cnt;
    reg                aw_held;
    reg                w_held;
    reg  [`ADDR_W-1:0] aw_addr;
    reg  [31:0]        w_data;
    reg  [3:0]         w_strb;
    reg                sel_bit;
    integer            i;
    integer            j;

    wire [`ENT_W-1:0]  cur_entry = table_ram[entry_ptr];
    wire [4:0]         cur_code  = cur_entry[4:0];
    wire               cur_nxm   = cur_entry[`NXM_BIT];
    wire               tick      = (div_cnt == HALF_BIT[7:0] - 8'h01);
    wire               do_write  = aw_held && w_held && !s_axi_bvalid;
    wire               wr_ram    = aw_addr[`RRS_BIT];
    wire [4:0]         wr_word   = aw_addr[6:2];
    wire               ctrl_send = do_write && !wr_ram && aw_addr[6:0] == `OFF_CTRL
                                   && w_strb[1] && w_data[`CTRL_SEND_BIT];

    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;
    assign busy          = (state != `ST_IDLE);

    // power-on table layout: twelve-bit drivers, fast decay fixed on
    function [`ENT_W-1:0] default_entry;
        input integer idx;
        integer k;
        begin
            k = idx % `DEF_DRIVER_LEN;
            if (idx >= `DEF_ENTRIES)
                default_entry = 6'h00;
            else if (k == 0 || k == 6)
                default_entry = {1'b0, `CODE_ONE};
            else if (k < 5)
                default_entry = 6'h06 - k[5:0];
            else if (k == 5)
                default_entry = 6'h06;
            else if (k < 11)
                default_entry = 6'h14 - k[5:0];
            else
                default_entry = 6'h2e;
        end
    endfunction

    // bit selection from the snapshot of the addressed motor
    always @*
    begin
        sel_bit = 1'b0;
        if (cur_code <= `CODE_COIL_LAST)
            sel_bit = snap_coil[{motor_driver_address, cur_code[3:0]}];
        else if (cur_code == `CODE_ZERO)
            sel_bit = 1'b0;
        else if (cur_code == `CODE_ONE)
            sel_bit = 1'b1;
        else if (cur_code == `CODE_DIR)
            sel_bit = snap_dir[motor_driver_address];
        else if (cur_code == `CODE_STEP)
            sel_bit = snap_step[motor_driver_address];
        else
            sel_bit = 1'b0;
    end

    // axi write channel and table / register writes
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held           <= 1'b0;
            w_held            <= 1'b0;
            aw_addr           <= {`ADDR_W{1'b0}};
            w_data            <= 32'h0;
            w_strb            <= 4'h0;
            s_axi_bvalid      <= 1'b0;
            s_axi_bresp       <= `RESP_OKAY;
            last_driver_index <= `LAST_RST;
            for (i = 0; i < `TAB_ENTRIES; i = i + 1)
                table_ram[i] <= default_entry(i);
        end
        else
        begin
            if (s_axi_awvalid && !aw_held)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                if (wr_ram)
                begin
                    if (w_strb[0])
                        table_ram[{wr_word, 1'b0}] <= w_data[`EVEN_LSB +: `ENT_W];
                    if (w_strb[0] && w_strb[1])
                        table_ram[{wr_word, 1'b1}] <= w_data[`ODD_LSB +: `ENT_W];
                end
                else if (aw_addr[6:0] == `OFF_CTRL)
                begin
                    if (w_strb[0])
                        last_driver_index <= w_data[`CTRL_LAST_MSB:`CTRL_LAST_LSB];
                end
                else if (aw_addr[6:0] != `OFF_STATUS)
                    s_axi_bresp <= `RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // axi read channel
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            s_axi_rdata  <= 32'h0;
            if (s_axi_araddr[`RRS_BIT])
                s_axi_rdata[11:0] <= {table_ram[{s_axi_araddr[6:2], 1'b1}],
                                      table_ram[{s_axi_araddr[6:2], 1'b0}]};
            else if (s_axi_araddr[6:0] == `OFF_CTRL)
                s_axi_rdata[`CTRL_LAST_MSB:`CTRL_LAST_LSB] <= last_driver_index;
            else if (s_axi_araddr[6:0] == `OFF_STATUS)
            begin
                s_axi_rdata[`STAT_BUSY_BIT] <= busy;
                s_axi_rdata[`STAT_ADDR_MSB:`STAT_ADDR_LSB] <= motor_driver_address;
            end
            else
                s_axi_rresp <= `RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // serial sequencer
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state                <= `ST_IDLE;
            pending              <= 1'b0;
            div_cnt              <= 8'h00;
            entry_ptr            <= 6'h00;
            motor_driver_address <= 2'h0;
            snap_coil            <= {16*MOTORS{1'b0}};
            snap_dir             <= {MOTORS{1'b0}};
            snap_step            <= {MOTORS{1'b0}};
            drv_sclk             <= 1'b1;
            drv_mosi             <= 1'b0;
            drv_cs_n             <= 1'b1;
        end
        else
        begin
            if (send_request || ctrl_send)
                pending <= 1'b1;
            div_cnt <= (state == `ST_IDLE || tick) ? 8'h00 : div_cnt + 8'h01;
            case (state)
                `ST_IDLE:
                begin
                    if (pending)
                    begin
                        pending <= send_request || ctrl_send;
                        for (j = 0; j < MOTORS; j = j + 1)
                            snap_coil[16*j +: 16] <= {coil_b_fast_decay[j],
                                coil_b_phase_polarity[j], coil_b_current[6*j +: 6],
                                coil_a_fast_decay[j], coil_a_phase_polarity[j],
                                coil_a_current[6*j +: 6]};
                        snap_dir             <= direction;
                        snap_step            <= step;
                        entry_ptr            <= 6'h00;
                        motor_driver_address <= 2'h0;
                        drv_cs_n             <= 1'b0;
                        state                <= `ST_SETUP;
                    end
                end
                `ST_SETUP:
                    if (tick)
                        state <= `ST_LOW;
                `ST_LOW:
                begin
                    drv_sclk <= 1'b0;
                    drv_mosi <= sel_bit;
                    if (tick)
                        state <= `ST_HIGH;
                end
                `ST_HIGH:
                begin
                    drv_sclk <= 1'b1;
                    if (tick)
                    begin
                        entry_ptr <= entry_ptr + 6'h01;
                        state     <= `ST_LOW;
                        if (cur_nxm && motor_driver_address == last_driver_index)
                        begin
                            motor_driver_address <= 2'h0;
                            state                <= `ST_HOLD;
                        end
                        else if (cur_nxm)
                            motor_driver_address <= motor_driver_address + 2'h1;
                    end
                end
                `ST_HOLD:
                    if (tick)
                    begin
                        drv_cs_n <= 1'b1;
                        drv_mosi <= 1'b0;
                        state    <= `ST_IDLE;
                    end
                default:
                    state <= `ST_IDLE;
            endcase
        end
    end

endmodule

//--- tb/chain_model.sv
`timescale 1ns/100ps
module chain_model (
    // clock and reset
    input  logic        aclk,
    input  logic        aresetn,
    // serial chain
    input  logic        drv_sclk,
    input  logic        drv_mosi,
    input  logic        drv_cs_n,
    // received frame
    output logic        rx_done,
    output logic [63:0] rx_bits,
    output logic [7:0]  rx_n
);
    logic prev_sclk;
    logic prev_cs_n;
    // shift on rising link clock in a frame, report at frame end
    always @(posedge aclk)
    begin
        prev_sclk <= drv_sclk;
        prev_cs_n <= drv_cs_n;
        rx_done <= 1'b0;
        if (!aresetn)
        begin
            rx_n <= 8'h00;
            rx_bits <= 64'h0;
            prev_cs_n <= 1'b1;
        end
        else if (drv_cs_n && !prev_cs_n)
            rx_done <= 1'b1;
        else if (!drv_cs_n && prev_cs_n)
        begin
            rx_n <= 8'h00;
            rx_bits <= 64'h0;
        end
        else if (!drv_cs_n && drv_sclk && !prev_sclk)
        begin
            rx_bits <= {rx_bits[62:0], drv_mosi};
            rx_n <= rx_n + 8'h01;
        end
    end
endmodule

//--- tb/seq_asserts.sv
`timescale 1ns/100ps
`include "datagram_seq_consts.vh"
module seq_asserts #(
    parameter MOTORS   = 3,
    parameter HALF_BIT = 8
) (
    // clock and reset
    input logic               aclk,
    input logic               aresetn,
    // bus handshakes
    input logic               s_axi_awvalid,
    input logic               s_axi_awready,
    input logic               s_axi_wvalid,
    input logic               s_axi_wready,
    input logic [1:0]         s_axi_bresp,
    input logic               s_axi_bvalid,
    input logic               s_axi_bready,
    input logic [`ADDR_W-1:0] s_axi_araddr,
    input logic               s_axi_arvalid,
    input logic               s_axi_arready,
    input logic [31:0]        s_axi_rdata,
    input logic [1:0]         s_axi_rresp,
    input logic               s_axi_rvalid,
    input logic               s_axi_rready,
    // driver chain
    input logic               drv_sclk,
    input logic               drv_mosi,
    input logic               drv_cs_n,
    input logic               busy
);
    logic [15:0] low_cnt;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // cycles the serial clock has been low
    always @(posedge aclk)
        if (!aresetn || drv_sclk)
            low_cnt <= 16'h0000;
        else
            low_cnt <= low_cnt + 16'h0001;
    idle_quiet_a: assert property (!busy |-> drv_cs_n && drv_sclk && !drv_mosi)
        else $error("chain active while idle");
    frame_busy_a: assert property (!drv_cs_n |-> busy)
        else $error("frame outside busy");
    bit_stable_a: assert property ($rose(drv_sclk) && !drv_cs_n |-> $stable(drv_mosi))
        else $error("data moved at sample edge");
    low_width_a: assert property ($rose(drv_sclk) && !drv_cs_n |-> low_cnt == HALF_BIT)
        else $error("serial clock low phase wrong");
    end_idle_a: assert property ($rose(drv_cs_n) |-> ##[0:1] !busy)
        else $error("no return to idle");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h08
        |=> s_axi_rresp == `RESP_SLVERR)
        else $error("unmapped read accepted");
    table_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[`RRS_BIT]
        |=> s_axi_rresp == `RESP_OKAY && s_axi_rdata[31:12] == 20'h00000)
        else $error("table read malformed");
endmodule

//--- tb/test_driver_chain_datagram_sequencer.sv
`timescale 1ns/100ps
`include "datagram_seq_consts.vh"
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_driver_chain_datagram_sequencer;
    logic aclk, aresetn, send_request, drv_sclk, drv_mosi, drv_cs_n, busy, rx_done;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rx_n;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, last;
    logic [53:0] mi;
    logic [63:0] rx_bits;
    logic [5:0] tab [64];
    logic [71:0] fq [$];
    logic [33:0] rq [$];
    logic [71:0] ef;
    logic [33:0] er;
    int n_mismatch, n_tests;
    localparam logic [5:0] DEF [12] = '{6'h11, 6'h05, 6'h04, 6'h03, 6'h02, 6'h06,
                                        6'h11, 6'h0d, 6'h0c, 6'h0b, 6'h0a, 6'h2e};
    driver_chain_datagram_sequencer #(.HALF_BIT(2)) driver_chain_datagram_sequencer_i (.*,
        .coil_a_current(mi[17:0]), .coil_b_current(mi[35:18]),
        .coil_a_phase_polarity(mi[38:36]), .coil_a_fast_decay(mi[41:39]),
        .coil_b_phase_polarity(mi[44:42]), .coil_b_fast_decay(mi[47:45]),
        .direction(mi[50:48]), .step(mi[53:51]));
    chain_model chain_model_i (.*);
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task complete_run;
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic step(inout int t);
        @(posedge aclk);
        t++;
        if (t > 3000)
        begin
            n_mismatch++;
            complete_run;
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic sel(input logic [4:0] c, input int m);
        int k = c[2:0];
        if (c < 16)
            sel = (k < 6) ? mi[18*c[3] + 6*m + k] : mi[36 + 6*c[3] + 3*(k-6) + m];
        else
            sel = (c == 17) | (c == 18 & mi[48+m]) | (c == 19 & mi[51+m]);
    endfunction
    // walk the shadow table from entry 0, motor 0
    task automatic expect_frame;
        int p = 0;
        int m = 0;
        int n = 0;
        logic [63:0] b = 64'h0;
        while (p < 64)
        begin
            b = {b[62:0], sel(tab[p][4:0], m)};
            n++;
            if (tab[p][5] && m == last)
                break;
            m += tab[p][5];
            p++;
        end
        fq.push_back({n[7:0], b});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int t = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            step(t);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int t = 0;
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            step(t);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic send(input logic by_reg);
        int t = 0;
        seed = lfsr(seed);
        mi <= {seed[21:0], lfsr(seed)};
        seed = lfsr(lfsr(seed));
        @(posedge aclk);
        expect_frame();
        if (by_reg)
            wr(8'h00, {23'h0, 1'b1, 6'h0, last});
        else
        begin
            send_request <= 1'b1;
            @(posedge aclk);
            send_request <= 1'b0;
        end
        while (busy !== 1'b1) step(t);
        mi <= ~mi;
        rd(8'h84, {22'h0, tab[3], tab[2]});
        while (busy !== 1'b0) step(t);
        repeat (2) @(posedge aclk);
    endtask
    // results in the order they were noted
    always @(posedge aclk)
    begin
        if (rx_done)
        begin
            ef = fq.pop_front();
            `CHK("frame", ef, {rx_n, rx_bits})
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            er = rq.pop_front();
            `CHK("read", er, {s_axi_rresp, s_axi_rdata})
        end
    end
    initial
    begin
        int t = 0;
        n_mismatch = 0;
        n_tests = 0;
        seed = 32'h74b8;
        last = 2'h2;
        {aresetn, send_request, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, mi} = '0;
        s_axi_wstrb = 4'hf;
        for (int i = 0; i < 64; i++) tab[i] = i < 36 ? DEF[i % 12] : 6'h00;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00, 34'h2);
        rd(8'h04, 34'h0);
        rd(8'h80, {22'h0, tab[1], tab[0]});
        rd(8'h08, {`RESP_SLVERR, 32'h0});
        repeat (40) @(posedge aclk);
        send(1'b0);
        send(1'b0);
        rd(8'h04, 34'h0);
        for (int i = 0; i < 64; i++) tab[i] = {i == 19 || i == 31 || i == 51, 5'(i % 32)};
        for (int w = 0; w < 32; w++) wr(8'(8'h80 + 4*w), {20'h0, tab[2*w+1], tab[2*w]});
        send(1'b1);
        last = 2'h1;
        send(1'b1);
        for (int w = 0; w < 32; w++) wr(8'(8'h80 + 4*w), 32'h451);
        wr(8'h00, 32'h102);
        while (busy !== 1'b1) step(t);
        repeat (600) @(posedge aclk);
        `CHK("endless", 1'b1, busy)
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        last = 2'h2;
        for (int i = 0; i < 64; i++) tab[i] = i < 36 ? DEF[i % 12] : 6'h00;
        send(1'b0);
        for (int i = 1; i < 4; i++) tab[i] = {1'b0, `CODE_ONE};
        wr(8'h80, {20'h0, tab[1], tab[0]});
        wr(8'h84, {20'h0, tab[3], tab[2]});
        send(1'b0);
        `CHK("left", 0, fq.size())
        complete_run;
    end
endmodule
bind driver_chain_datagram_sequencer seq_asserts #(.MOTORS(MOTORS), .HALF_BIT(HALF_BIT))
    seq_asserts_i (.*);
